// ==== rtl/adc_serial_command_decoder.sv ====
// Serial command port: command decode, register transfer and resync
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_decoder #(
    parameter int NUM_CHANNELS = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic conversion_done,
    output logic sdo_out,
    output logic sdo_oe,
    output logic convert_start,
    output logic calibrate_start,
    output logic continuous_mode,
    output logic [2:0] setup_pointer,
    output logic [2:0] operation_type,
    output logic conversion_flag,
    output logic command_mode
);
    typedef enum logic [1:0] {ST_COMMAND, ST_WRITE, ST_READ} port_state_e;

    localparam logic [2:0] CHANNELS = 3'(NUM_CHANNELS);

    reg_mem_if mem_bus ();

    reg_store u_store (
        .clock(clock),
        .rst(rst),
        .bus(mem_bus.store)
    );

    // Pins: {cs_n, sclk, sdi}
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic sclk_prev_reg;
    port_state_e state_reg;
    logic [4:0] bit_cnt_reg;
    logic [31:0] shift_in_reg;
    logic [2:0] words_left_reg;
    logic [3:0] addr_reg;
    logic [31:0] out_shift_reg;
    logic shift_pending_reg;
    logic rd_p1_reg;
    logic rd_p2_reg;
    logic [6:0] ones_cnt_reg;

    logic selected;
    logic sdi_s;
    logic rise;
    logic fall;
    logic resync_hit;
    logic [7:0] cmd;
    logic acc_ok;
    logic [2:0] acc_words;
    logic [3:0] acc_base;
    logic op_ok;
    logic cmd_done;
    logic word_done;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            // Idle levels: deselected, clock low, so no false edge follows
            pin_meta_reg <= 3'h4;
            pin_sync_reg <= 3'h4;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= {cs_n_pin, sclk_pin, sdi_pin};
            pin_sync_reg <= pin_meta_reg;
            sclk_prev_reg <= pin_sync_reg[1];
        end
    end

    assign selected = ~pin_sync_reg[2];
    assign sdi_s = pin_sync_reg[0];
    assign rise = selected & pin_sync_reg[1] & ~sclk_prev_reg;
    assign fall = selected & ~pin_sync_reg[1] & sclk_prev_reg;
    assign cmd = {shift_in_reg[6:0], sdi_s};
    assign resync_hit = rise & ~sdi_s & (ones_cnt_reg == adc_cmd_pkg::RESYNC_ONES);
    assign cmd_done = rise & (state_reg == ST_COMMAND)
        & (bit_cnt_reg == 5'(adc_cmd_pkg::CMD_BITS - 1)) & ~resync_hit;
    assign word_done = rise & (state_reg != ST_COMMAND)
        & (bit_cnt_reg == 5'(adc_cmd_pkg::WORD_BITS - 1)) & ~resync_hit;
    assign mem_bus.raddr = addr_reg;

    // Access decode of the byte completing on this edge
    always_comb
    begin
        acc_ok = 1'b0;
        acc_words = 3'h1;
        acc_base = adc_cmd_pkg::IDX_CONFIG;
        case (cmd[adc_cmd_pkg::CODE_HI:0])
            adc_cmd_pkg::REG_OFFSET, adc_cmd_pkg::REG_GAIN:
            begin
                acc_ok = cmd[adc_cmd_pkg::BIT_ARRAY]
                    | ({1'b0, cmd[adc_cmd_pkg::CH_HI:adc_cmd_pkg::CH_LO]}
                    < CHANNELS);
                acc_words = cmd[adc_cmd_pkg::BIT_ARRAY] ? CHANNELS : 3'h1;
                acc_base = (cmd[0] ? adc_cmd_pkg::BASE_OFFSET
                    : adc_cmd_pkg::BASE_GAIN);
            end
            adc_cmd_pkg::REG_SETUP:
            begin
                acc_ok = 1'b1;
                acc_words = cmd[adc_cmd_pkg::BIT_ARRAY]
                    ? adc_cmd_pkg::SETUP_REGS : 3'h1;
                acc_base = adc_cmd_pkg::BASE_SETUP;
            end
            adc_cmd_pkg::REG_CONFIG:
            begin
                acc_ok = 1'b1;
            end
            default:
            begin
                acc_ok = 1'b0;
            end
        endcase
        if (!cmd[adc_cmd_pkg::BIT_ARRAY]
            && cmd[adc_cmd_pkg::CODE_HI:0] != adc_cmd_pkg::REG_CONFIG)
            acc_base = acc_base
                + {2'h0, cmd[adc_cmd_pkg::CH_HI:adc_cmd_pkg::CH_LO]};
        case (cmd[adc_cmd_pkg::CODE_HI:0])
            adc_cmd_pkg::OP_NORMAL:
                op_ok = 1'b1;
            adc_cmd_pkg::OP_SELF_OFFSET, adc_cmd_pkg::OP_SELF_GAIN,
            adc_cmd_pkg::OP_SYS_OFFSET, adc_cmd_pkg::OP_SYS_GAIN:
                op_ok = ~cmd[adc_cmd_pkg::BIT_ARRAY];
            default:
                op_ok = 1'b0;
        endcase
    end

    // Port sequencing; deselect aborts a transfer
    always_ff @(posedge clock)
    begin
        if (rst || !selected || resync_hit)
        begin
            state_reg <= ST_COMMAND;
            bit_cnt_reg <= 5'h00;
            words_left_reg <= 3'h0;
        end
        else if (cmd_done)
        begin
            bit_cnt_reg <= 5'h00;
            if (!cmd[adc_cmd_pkg::BIT_CLASS] && acc_ok)
            begin
                state_reg <= cmd[adc_cmd_pkg::BIT_DIR] ? ST_READ : ST_WRITE;
                words_left_reg <= acc_words;
            end
        end
        else if (word_done)
        begin
            bit_cnt_reg <= 5'h00;
            words_left_reg <= words_left_reg - 3'h1;
            if (words_left_reg == 3'h1)
                state_reg <= ST_COMMAND;
        end
        else if (rise)
        begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            addr_reg <= 4'h0;
        else if (cmd_done)
            addr_reg <= acc_base;
        else if (word_done)
            addr_reg <= addr_reg + 4'h1;
    end

    always_ff @(posedge clock)
    begin
        if (rst || !selected)
            ones_cnt_reg <= 7'h00;
        else if (rise && !sdi_s)
            ones_cnt_reg <= 7'h00;
        else if (rise && ones_cnt_reg != adc_cmd_pkg::RESYNC_ONES)
            ones_cnt_reg <= ones_cnt_reg + 7'h01;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            shift_in_reg <= 32'h00000000;
        else if (rise)
            shift_in_reg <= {shift_in_reg[30:0], sdi_s};
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mem_bus.we <= 1'b0;
            mem_bus.waddr <= 4'h0;
            mem_bus.wdata <= 32'h00000000;
        end
        else
        begin
            mem_bus.we <= word_done & (state_reg == ST_WRITE);
            mem_bus.waddr <= addr_reg;
            mem_bus.wdata <= {shift_in_reg[30:0], sdi_s};
        end
    end

    // Read words load two cycles after the address moves, long before the
    // next falling edge of a link clock that is far slower than ours
    always_ff @(posedge clock)
    begin
        if (rst || !selected || resync_hit)
        begin
            rd_p1_reg <= 1'b0;
            rd_p2_reg <= 1'b0;
            shift_pending_reg <= 1'b0;
            out_shift_reg <= 32'h00000000;
        end
        else
        begin
            rd_p1_reg <= (cmd_done & ~cmd[adc_cmd_pkg::BIT_CLASS] & acc_ok
                & cmd[adc_cmd_pkg::BIT_DIR])
                | (word_done & (state_reg == ST_READ)
                & (words_left_reg != 3'h1));
            rd_p2_reg <= rd_p1_reg;
            if (rd_p2_reg)
                out_shift_reg <= mem_bus.rdata;
            else if (fall && shift_pending_reg)
                out_shift_reg <= {out_shift_reg[30:0], 1'b0};
            if (rise && state_reg == ST_READ && !word_done)
                shift_pending_reg <= 1'b1;
            else if (fall)
                shift_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sdo_out <= 1'b0;
            sdo_oe <= 1'b0;
            command_mode <= 1'b1;
        end
        else
        begin
            sdo_out <= out_shift_reg[31];
            sdo_oe <= selected;
            command_mode <= (state_reg == ST_COMMAND);
        end
    end

    // Conversion and calibration launch
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            convert_start <= 1'b0;
            calibrate_start <= 1'b0;
            continuous_mode <= 1'b0;
            setup_pointer <= 3'h0;
            operation_type <= 3'h0;
        end
        else
        begin
            convert_start <= 1'b0;
            calibrate_start <= 1'b0;
            if (cmd_done && cmd[adc_cmd_pkg::BIT_CLASS] && op_ok)
            begin
                setup_pointer <= cmd[adc_cmd_pkg::PTR_HI:adc_cmd_pkg::PTR_LO];
                operation_type <= cmd[adc_cmd_pkg::CODE_HI:0];
                if (cmd[adc_cmd_pkg::CODE_HI:0] == adc_cmd_pkg::OP_NORMAL)
                begin
                    convert_start <= 1'b1;
                    continuous_mode <= cmd[adc_cmd_pkg::BIT_ARRAY];
                end
                else
                begin
                    calibrate_start <= 1'b1;
                    continuous_mode <= 1'b0;
                end
            end
        end
    end

    // Set wins so a result finishing with the null byte is still flagged
    always_ff @(posedge clock)
    begin
        if (rst)
            conversion_flag <= 1'b0;
        else if (conversion_done)
            conversion_flag <= 1'b1;
        else if (cmd_done && cmd == 8'h00 && continuous_mode)
            conversion_flag <= 1'b0;
    end
endmodule
`default_nettype wire

// ==== rtl/adc_cmd_pkg.sv ====
// Constants shared by the serial command decoder and its register store
package adc_cmd_pkg;
    // Command byte field positions
    localparam int BIT_CLASS = 7;
    localparam int BIT_ARRAY = 6;
    localparam int CH_HI = 5;
    localparam int CH_LO = 4;
    localparam int BIT_DIR = 3;
    localparam int PTR_HI = 5;
    localparam int PTR_LO = 3;
    localparam int CODE_HI = 2;
    // Register type codes of an access command
    localparam logic [2:0] REG_OFFSET = 3'h1;
    localparam logic [2:0] REG_GAIN = 3'h2;
    localparam logic [2:0] REG_CONFIG = 3'h3;
    localparam logic [2:0] REG_SETUP = 3'h5;
    // Operation codes of a conversion command
    localparam logic [2:0] OP_NORMAL = 3'h0;
    localparam logic [2:0] OP_SELF_OFFSET = 3'h1;
    localparam logic [2:0] OP_SELF_GAIN = 3'h2;
    localparam logic [2:0] OP_SYS_OFFSET = 3'h5;
    localparam logic [2:0] OP_SYS_GAIN = 3'h6;
    // Transfer sizes
    localparam int CMD_BITS = 8;
    localparam int WORD_BITS = 32;
    localparam logic [2:0] SETUP_REGS = 3'h4;
    // 15 fill bytes plus the seven leading ones of the end byte
    localparam logic [6:0] RESYNC_ONES = 7'h7F;
    // Register store word indices
    localparam logic [3:0] BASE_OFFSET = 4'h0;
    localparam logic [3:0] BASE_GAIN = 4'h4;
    localparam logic [3:0] BASE_SETUP = 4'h8;
    localparam logic [3:0] IDX_CONFIG = 4'hC;
    // Reset values
    localparam logic [31:0] RST_OFFSET = 32'h00000000;
    localparam logic [31:0] RST_GAIN = 32'h01000000;
    localparam logic [31:0] RST_SETUP = 32'h00000000;
    localparam logic [31:0] RST_CONFIG = 32'h00000000;
endpackage

// ==== rtl/reg_mem_if.sv ====
// Write and read port between the decoder and its register store
`timescale 1ns/1ps
`default_nettype none
interface reg_mem_if;
    logic we;
    logic [3:0] waddr;
    logic [31:0] wdata;
    logic [3:0] raddr;
    logic [31:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr,
        input rdata);
    modport store (input we, input waddr, input wdata, input raddr,
        output rdata);
endinterface
`default_nettype wire

// ==== rtl/reg_store.sv ====
// Offset, gain, setup and configuration words with a registered read port
`timescale 1ns/1ps
`default_nettype none
module reg_store (
    input wire logic clock,
    input wire logic rst,
    reg_mem_if.store bus
);
    logic [31:0] mem_reg [16];

    function automatic logic [31:0] reset_value(input logic [3:0] idx);
        if (idx >= adc_cmd_pkg::IDX_CONFIG)
            reset_value = adc_cmd_pkg::RST_CONFIG;
        else if (idx >= adc_cmd_pkg::BASE_SETUP)
            reset_value = adc_cmd_pkg::RST_SETUP;
        else if (idx >= adc_cmd_pkg::BASE_GAIN)
            reset_value = adc_cmd_pkg::RST_GAIN;
        else
            reset_value = adc_cmd_pkg::RST_OFFSET;
    endfunction

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int i = 0; i < 16; i++)
                mem_reg[i] <= reset_value(4'(i));
        end
        else if (bus.we)
        begin
            mem_reg[bus.waddr] <= bus.wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            bus.rdata <= 32'h00000000;
        else
            bus.rdata <= mem_reg[bus.raddr];
    end
endmodule
`default_nettype wire

// ==== testbench/adc_cmd_host.sv ====
// Host model that drives the serial command port
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_host (
    input wire logic clock,
    input wire logic sdo_out,
    output logic cs_n_pin,
    output logic sclk_pin,
    output logic sdi_pin
);
    initial
    begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        sdi_pin = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic shift(input logic [31:0] w, input int n,
        output logic [31:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi_pin = w[i];
            hold(10);
            sclk_pin = 1'b1;
            r = {r[30:0], sdo_out};
            hold(10);
            sclk_pin = 1'b0;
        end
        // Idle data line shows the inverse, never a stale bit
        sdi_pin = ~sdi_pin;
    endtask
    task automatic frame(input logic on);
        hold(6);
        cs_n_pin = ~on;
        hold(6);
    endtask
endmodule
`default_nettype wire

// ==== testbench/adc_serial_command_decoder_assertions.sv ====
// Port checker for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_checker #(
    parameter int NUM_CHANNELS = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic conversion_done,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic convert_start,
    input wire logic calibrate_start,
    input wire logic continuous_mode,
    input wire logic [2:0] setup_pointer,
    input wire logic [2:0] operation_type,
    input wire logic conversion_flag,
    input wire logic command_mode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    AST_START_EXCL: assert property (
        !(convert_start && calibrate_start))
        else $error("conversion and calibration started together");
    AST_CONV_NORMAL: assert property (
        convert_start |-> operation_type == adc_cmd_pkg::OP_NORMAL)
        else $error("conversion started with a calibration code");
    AST_CAL_CODE: assert property (
        calibrate_start |-> !continuous_mode && operation_type inside
        {3'h1, 3'h2, 3'h5, 3'h6})
        else $error("calibration started with a bad code or mode");
    AST_PULSE_ONE: assert property (
        convert_start || calibrate_start |=> !convert_start && !calibrate_start)
        else $error("start pulse longer than one cycle");
    AST_LEVELS_HOLD: assert property (
        !convert_start && !calibrate_start |-> $stable(setup_pointer) &&
        $stable(operation_type) && $stable(continuous_mode))
        else $error("mode outputs changed without a command");
    AST_FLAG_SET: assert property (
        conversion_done |=> conversion_flag)
        else $error("flag not set after conversion done");
    AST_FLAG_CAUSE: assert property (
        !conversion_done && !conversion_flag |=> !conversion_flag)
        else $error("flag set without conversion done");
    AST_IDLE_PORT: assert property (
        cs_n_pin [*5] |-> !sdo_oe && command_mode)
        else $error("deselected port not idle in command mode");
    AST_OE_ON: assert property (
        !cs_n_pin [*5] |-> sdo_oe)
        else $error("output not enabled while selected");
    cover property (convert_start && continuous_mode);
    cover property (calibrate_start);
    cover property ($fell(command_mode));
endmodule
bind adc_serial_command_decoder adc_cmd_checker #(
    .NUM_CHANNELS(NUM_CHANNELS)) u_chk (.clock(clock), .rst(rst),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
    .conversion_done(conversion_done), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .convert_start(convert_start), .calibrate_start(calibrate_start),
    .continuous_mode(continuous_mode), .setup_pointer(setup_pointer),
    .operation_type(operation_type), .conversion_flag(conversion_flag),
    .command_mode(command_mode));
`default_nettype wire

// ==== testbench/test_adc_serial_command_decoder.sv ====
// Self-checking bench for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_command_decoder;
    logic clock, rst, cs_n_pin, sclk_pin, sdi_pin, conversion_done;
    logic sdo_out, sdo_oe, convert_start, calibrate_start, continuous_mode;
    logic [2:0] setup_pointer, operation_type;
    logic conversion_flag, command_mode;
    logic [31:0] rd;
    int bad_count = 0, n_checks = 0, n_conv = 0, n_cal = 0;
    adc_serial_command_decoder #(.NUM_CHANNELS(4)) u_dut (.clock(clock),
        .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .sdi_pin(sdi_pin), .conversion_done(conversion_done),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .convert_start(convert_start),
        .calibrate_start(calibrate_start), .continuous_mode(continuous_mode),
        .setup_pointer(setup_pointer), .operation_type(operation_type),
        .conversion_flag(conversion_flag), .command_mode(command_mode));
    adc_cmd_host u_host (.clock(clock), .sdo_out(sdo_out),
        .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin));
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(negedge clock)
    begin
        if (convert_start === 1'b1) n_conv++;
        if (calibrate_start === 1'b1) n_cal++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One framed command and n words; reads compare against d + index
    task automatic xfer(input logic [7:0] c, input int n, input logic [31:0] d);
        u_host.frame(1'b1);
        u_host.shift({24'h0, c}, 8, rd);
        for (int i = 0; i < n; i++)
        begin
            u_host.shift(d + i, 32, rd);
            if (c[3]) chk(rd, d + i);
        end
        chk(command_mode, 1'b1);
        u_host.frame(1'b0);
    endtask
    // A command byte with no data words behind it
    task automatic send_cmd(input logic [7:0] c);
        xfer(c, 0, '0);
    endtask
    task automatic t_single;
        logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h5, 3'h3};
        foreach (codes[i])
        begin
            xfer({4'h3, 1'b0, codes[i]}, 1, 32'hA5C30F10 ^ i);
            xfer({4'h3, 1'b1, codes[i]}, 1, 32'hA5C30F10 ^ i);
        end
        xfer(8'h2A, 1, 32'h01000000);
        xfer(8'h29, 1, 32'h00000000);
        xfer(8'h2D, 1, 32'h00000000);
    endtask
    task automatic t_array;
        logic [2:0] codes [3] = '{3'h1, 3'h2, 3'h5};
        foreach (codes[i])
        begin
            xfer({5'h08, codes[i]}, 4, 32'h10000000 * (i + 1));
            xfer({5'h09, codes[i]}, 4, 32'h10000000 * (i + 1));
            xfer({5'h05, codes[i]}, 1, 32'h10000000 * (i + 1) + 2);
        end
    endtask
    task automatic t_conv;
        logic [2:0] ops [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
        int cv, cl;
        foreach (ops[i])
        begin
            cv = n_conv;
            cl = n_cal;
            send_cmd({2'b10, ops[i] + 3'h1, ops[i]});
            chk(n_conv - cv, ops[i] == 3'h0);
            chk(n_cal - cl, ops[i] != 3'h0);
            chk(operation_type, ops[i]);
            chk(setup_pointer, ops[i] + 3'h1);
        end
        send_cmd(8'hD0);
        chk(continuous_mode, 1'b1);
        chk(setup_pointer, 3'h2);
    endtask
    task automatic t_refuse;
        logic [7:0] bad [3] = '{8'h06, 8'h84, 8'hC1};
        int cv;
        cv = n_conv + n_cal;
        foreach (bad[i]) send_cmd(bad[i]);
        chk(n_conv + n_cal - cv, 0);
        chk({continuous_mode, setup_pointer}, 4'hA);
        xfer(8'h0A, 1, 32'h20000000);
    endtask
    task automatic t_null;
        conversion_done = 1'b1;
        u_host.hold(1);
        conversion_done = 1'b0;
        u_host.hold(1);
        chk(conversion_flag, 1'b1);
        send_cmd(8'h00);
        chk({conversion_flag, continuous_mode}, 2'b01);
    endtask
    task automatic t_resync;
        u_host.frame(1'b1);
        // A read keeps the store intact while the ones run past a word end
        u_host.shift(32'h0A, 8, rd);
        u_host.shift(32'hFFF, 12, rd);
        repeat (15) u_host.shift(32'hFF, 8, rd);
        u_host.shift(32'hFE, 8, rd);
        chk(command_mode, 1'b1);
        // Same frame: the byte count must be realigned by the end byte
        u_host.shift(32'h0A, 8, rd);
        u_host.shift(32'h0, 32, rd);
        chk(rd, 32'h20000000);
        u_host.frame(1'b0);
        xfer(8'h0A, 1, 32'h20000000);
    endtask
    initial
    begin
        repeat (100000) @(posedge clock);
        bad_count++;
        tally_and_finish;
    end
    initial
    begin
        rst = 1'b1;
        conversion_done = 1'b0;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        u_host.hold(6);
        chk({command_mode, conversion_flag, continuous_mode}, 3'h4);
        t_single;
        t_array;
        t_conv;
        t_refuse;
        t_null;
        t_resync;
        tally_and_finish;
    end
endmodule
`default_nettype wire
